/* logic/brt_pkg.sv */
// shared constants for the registered bus transceiver
package brt_pkg;

  // data path shape
  localparam int HALF_W = 8;
  localparam int NUM_HALF = 2;
  localparam int BUS_W = HALF_W * NUM_HALF;
  localparam int CTL_PER_HALF = 6;

  // ahb-lite widths and encodings
  localparam int AHB_AW = 32;
  localparam int AHB_DW = 32;
  localparam int REG_AW = 8;
  localparam int HTRANS_ACT_BIT = 1;
  localparam logic HRESP_OKAY = 1'b0;

  // register byte offsets
  localparam logic [REG_AW-1:0] OFS_CTRL = 8'h00;
  localparam logic [REG_AW-1:0] OFS_CAPT = 8'h04;
  localparam logic [REG_AW-1:0] OFS_STORE = 8'h08;
  localparam logic [REG_AW-1:0] OFS_LOG = 8'h0C;
  localparam logic [REG_AW-1:0] OFS_STAT = 8'h10;
  localparam logic [REG_AW-1:0] OFS_PINS = 8'h14;

  // control register: one field of four bits per half, then override
  localparam int CTRL_FLD_W = 4;
  localparam int FLD_OEB = 0;
  localparam int FLD_OEA_N = 1;
  localparam int FLD_SELB = 2;
  localparam int FLD_SELA = 3;
  localparam int CTRL_OVR_BIT = 8;
  localparam logic [CTRL_FLD_W*NUM_HALF-1:0] CTRL_FLD_RST = 8'hFF & 8'h22;

  // capture strobe register: two bits per half
  localparam int CAPT_W = 2;
  localparam int CAPT_A = 0;
  localparam int CAPT_B = 1;

  // status register bits
  localparam int STAT_EMPTY = 0;
  localparam int STAT_FULL = 1;
  localparam int STAT_DROP = 2;

  // capture log
  localparam int LOG_W = 2 * BUS_W;
  localparam int LOG_DEPTH = 32;

endpackage

/* logic/brt_stream_if.sv */
// valid/ready carrier between the transceiver core and its capture log
`timescale 1ns/1ps
`default_nettype none
interface brt_stream_if #(parameter int W = 32);
  logic in_valid;
  logic in_ready;
  logic [W-1:0] in_data;
  logic out_valid;
  logic out_ready;
  logic [W-1:0] out_data;

  // the core fills and drains
  modport user (output in_valid, output in_data, input in_ready,
                input out_valid, input out_data, output out_ready);
  // the buffer itself
  modport store (input in_valid, input in_data, output in_ready,
                 output out_valid, output out_data, input out_ready);
endinterface
`default_nettype wire

/* logic/brt_sync.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module brt_sync #(
  parameter int W = 8,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // pins and filtered levels
  input wire logic [W-1:0] raw,
  output logic [W-1:0] filt
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] f;
  } brt_sync_st_t;

  brt_sync_st_t q;
  brt_sync_st_t nx;

  // s1 feeds only s2; a bit moves once s2 and s3 agree
  always_comb begin
    nx = q;
    nx.s1 = raw;
    nx.s2 = q.s1;
    nx.s3 = q.s2;
    nx.f = (~(q.s2 ^ q.s3) & q.s2) | ((q.s2 ^ q.s3) & q.f);
  end

  // reset values keep the drive enables idle until pins settle
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= {RST, RST, RST, RST};
    end else begin
      q <= nx;
    end
  end

  assign filt = q.f;

endmodule
`default_nettype wire

/* logic/brt_fifo.sv */
// capture log buffer, width and depth set by parameters
`timescale 1ns/1ps
`default_nettype none
module brt_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 32
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // both handshake sides
  brt_stream_if.store s
);

  localparam int AW = $clog2(DEPTH);

  // depth must be a power of two: pointers wrap by overflow
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } brt_fifo_st_t;

  brt_fifo_st_t q;
  brt_fifo_st_t nx;
  logic push;
  logic pop;

  // full refuses a push even when a pop happens in the same cycle
  assign s.in_ready = (q.cnt != (AW+1)'(DEPTH));
  assign s.out_valid = (q.cnt != '0);
  assign s.out_data = q.mem[q.rp];
  assign push = s.in_valid & s.in_ready;
  assign pop = s.out_valid & s.out_ready;

  // pointer and occupancy update
  always_comb begin
    nx = q;
    if (push) begin
      nx.mem[q.wp] = s.in_data;
      nx.wp = q.wp + 1'b1;
    end
    if (pop) begin
      nx.rp = q.rp + 1'b1;
    end
    nx.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= nx;
    end
  end

endmodule
`default_nettype wire

/* logic/brt_top.sv */
// registered bus transceiver: two halves, pin sync, capture log, ahb-lite regs
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - two independent 8-bit halves, usable together as one 16-bit path
// - each half has own capture clocks, source selects and drive enables
// - select low passes opposite bus live; select high drives stored register
// - changing a select never shows a spurious value on driven outputs
// - capture clock rising edge loads source pins, whatever selects and enables say
// - capture always active, even while the device drives that port
// - isolation: both ports inputs, clock edges still load both registers
// - both enables low: A drives live B, or stored B when selected
// - both enables high: B drives live A, or stored A when selected
// - B enabled, A enabled, both selects high: both ports drive stored data
// - B driven and both clocks rise: both registers take A-side data
// - A driven and both clocks rise: both registers take B-side data
// - live mode with both ports driving: each output reinforces its input
// - undriven data pins hold their last level
module brt_top (
  // bus clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [brt_pkg::AHB_AW-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [brt_pkg::AHB_DW-1:0] hwdata,
  input wire logic hready,
  output logic [brt_pkg::AHB_DW-1:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // per-half control pins, bit index is the half
  input wire logic [brt_pkg::NUM_HALF-1:0] b_side_drive_enable,
  input wire logic [brt_pkg::NUM_HALF-1:0] a_side_drive_enable_n,
  input wire logic [brt_pkg::NUM_HALF-1:0] b_output_source_select,
  input wire logic [brt_pkg::NUM_HALF-1:0] a_output_source_select,
  input wire logic [brt_pkg::NUM_HALF-1:0] a_capture_clock,
  input wire logic [brt_pkg::NUM_HALF-1:0] b_capture_clock,
  // a port pins
  input wire logic [brt_pkg::BUS_W-1:0] a_port_bit_i,
  output logic [brt_pkg::BUS_W-1:0] a_port_bit_o,
  output logic [brt_pkg::BUS_W-1:0] a_port_bit_oe,
  // b port pins
  input wire logic [brt_pkg::BUS_W-1:0] b_port_bit_i,
  output logic [brt_pkg::BUS_W-1:0] b_port_bit_o,
  output logic [brt_pkg::BUS_W-1:0] b_port_bit_oe,
  // capture log back-pressure
  output logic log_ready
);
  import brt_pkg::*;

  localparam int SW = CTL_PER_HALF * NUM_HALF + 2 * BUS_W;

  // drive-enable-low pins reset high so nothing drives before pins settle
  localparam logic [SW-1:0] SYNC_RST = {
    {(3 * NUM_HALF){1'b0}},
    {NUM_HALF{1'b1}},
    {(2 * NUM_HALF + 2 * BUS_W){1'b0}}
  };

  typedef struct packed {
    logic [BUS_W-1:0] a_store;
    logic [BUS_W-1:0] b_store;
    logic [BUS_W-1:0] a_out;
    logic [BUS_W-1:0] b_out;
    logic [BUS_W-1:0] a_oe;
    logic [BUS_W-1:0] b_oe;
    logic [NUM_HALF-1:0] clka_q;
    logic [NUM_HALF-1:0] clkb_q;
    logic ovr;
    logic [CTRL_FLD_W*NUM_HALF-1:0] fld;
    logic drop;
    logic ph_act;
    logic ph_wr;
    logic [REG_AW-1:0] ph_addr;
    logic [AHB_DW-1:0] rdata;
  } brt_top_st_t;

  brt_top_st_t q;
  brt_top_st_t nx;

  // filtered pin levels
  logic [SW-1:0] filt;
  logic [NUM_HALF-1:0] clka_f;
  logic [NUM_HALF-1:0] clkb_f;
  logic [NUM_HALF-1:0] oeb_f;
  logic [NUM_HALF-1:0] oea_n_f;
  logic [NUM_HALF-1:0] selb_f;
  logic [NUM_HALF-1:0] sela_f;
  logic [BUS_W-1:0] a_f;
  logic [BUS_W-1:0] b_f;

  // per-cycle events and bus decode
  logic [NUM_HALF-1:0] ev_a;
  logic [NUM_HALF-1:0] ev_b;
  logic [CAPT_W*NUM_HALF-1:0] sw_capt;
  logic wr_hit;
  logic drop_clr;
  logic acc;
  logic log_push;
  logic log_pop;

  brt_stream_if #(.W(LOG_W)) lg ();

  // choose a control source: register field under override, else the pin
  function automatic logic pick(input logic ovr, input logic fld, input logic pin);
    return ovr ? fld : pin;
  endfunction

  // read multiplexer, evaluated in the address phase
  function automatic logic [AHB_DW-1:0] rd_word(
    input logic [REG_AW-1:0] a,
    input brt_top_st_t s,
    input logic lg_valid,
    input logic lg_ready,
    input logic [LOG_W-1:0] lg_word,
    input logic [2*BUS_W-1:0] pins
  );
    logic [AHB_DW-1:0] r;
    r = '0;
    case (a)
      OFS_CTRL: begin
        r[CTRL_FLD_W*NUM_HALF-1:0] = s.fld;
        r[CTRL_OVR_BIT] = s.ovr;
      end
      OFS_STORE: begin
        r = {s.b_store, s.a_store};
      end
      OFS_LOG: begin
        r = lg_valid ? lg_word : '0;
      end
      OFS_STAT: begin
        r[STAT_EMPTY] = ~lg_valid;
        r[STAT_FULL] = ~lg_ready;
        r[STAT_DROP] = s.drop;
      end
      OFS_PINS: begin
        r = pins;
      end
      default: begin
        r = '0;
      end
    endcase
    return r;
  endfunction

  // every pin passes the three-stage filter; data and clocks share one
  // path so a clock edge and the data it samples stay aligned
  brt_sync #(
    .W(SW),
    .RST(SYNC_RST)
  ) u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .raw({a_capture_clock, b_capture_clock, b_side_drive_enable,
          a_side_drive_enable_n, b_output_source_select,
          a_output_source_select, a_port_bit_i, b_port_bit_i}),
    .filt(filt)
  );

  assign {clka_f, clkb_f, oeb_f, oea_n_f, selb_f, sela_f, a_f, b_f} = filt;

  // capture log of register snapshots
  brt_fifo #(
    .W(LOG_W),
    .DEPTH(LOG_DEPTH)
  ) u_log (
    .hclk(hclk),
    .hresetn(hresetn),
    .s(lg.store)
  );

  // data-phase write decode; zero wait states so hready is not rechecked
  assign wr_hit = q.ph_act & q.ph_wr;
  assign drop_clr = wr_hit & (q.ph_addr == OFS_STAT) & hwdata[STAT_DROP];
  assign sw_capt = (wr_hit && q.ph_addr == OFS_CAPT) ?
                   hwdata[CAPT_W*NUM_HALF-1:0] : '0;

  // address phase accepted on a nonseq or seq transfer
  assign acc = hsel & hready & htrans[HTRANS_ACT_BIT];
  assign log_pop = acc & ~hwrite & (haddr[REG_AW-1:0] == OFS_LOG) & lg.out_valid;

  // core next state
  always_comb begin
    logic oeb_e;
    logic oea_n_e;
    logic selb_e;
    logic sela_e;
    oeb_e = 1'b0;
    oea_n_e = 1'b1;
    selb_e = 1'b0;
    sela_e = 1'b0;
    nx = q;
    ev_a = '0;
    ev_b = '0;

    // control register write
    if (wr_hit && q.ph_addr == OFS_CTRL) begin
      nx.ovr = hwdata[CTRL_OVR_BIT];
      nx.fld = hwdata[CTRL_FLD_W*NUM_HALF-1:0];
    end

    for (int h = 0; h < NUM_HALF; h++) begin
      // each half runs from its own controls and clocks
      oeb_e = pick(q.ovr, q.fld[h*CTRL_FLD_W+FLD_OEB], oeb_f[h]);
      oea_n_e = pick(q.ovr, q.fld[h*CTRL_FLD_W+FLD_OEA_N], oea_n_f[h]);
      selb_e = pick(q.ovr, q.fld[h*CTRL_FLD_W+FLD_SELB], selb_f[h]);
      sela_e = pick(q.ovr, q.fld[h*CTRL_FLD_W+FLD_SELA], sela_f[h]);

      // rising edge of the filtered clock, or a software strobe
      ev_a[h] = (clka_f[h] & ~q.clka_q[h]) | sw_capt[h*CAPT_W+CAPT_A];
      ev_b[h] = (clkb_f[h] & ~q.clkb_q[h]) | sw_capt[h*CAPT_W+CAPT_B];

      // loads ignore selects and enables; the pin level seen includes
      // our own drive, so a driven port captures what we put on it
      if (ev_a[h]) begin
        nx.a_store[h*HALF_W +: HALF_W] = a_f[h*HALF_W +: HALF_W];
      end
      if (ev_b[h]) begin
        nx.b_store[h*HALF_W +: HALF_W] = b_f[h*HALF_W +: HALF_W];
      end
      // no edge: the register keeps its word, assigned only above

      // b side: live a or stored a; undriven bits follow the pin level
      nx.b_oe[h*HALF_W +: HALF_W] = {HALF_W{oeb_e}};
      if (!oeb_e) begin
        nx.b_out[h*HALF_W +: HALF_W] = b_f[h*HALF_W +: HALF_W];
      end else if (selb_e) begin
        nx.b_out[h*HALF_W +: HALF_W] = q.a_store[h*HALF_W +: HALF_W];
      end else begin
        nx.b_out[h*HALF_W +: HALF_W] = a_f[h*HALF_W +: HALF_W];
      end

      // a side: live b or stored b
      nx.a_oe[h*HALF_W +: HALF_W] = {HALF_W{~oea_n_e}};
      if (oea_n_e) begin
        nx.a_out[h*HALF_W +: HALF_W] = a_f[h*HALF_W +: HALF_W];
      end else if (sela_e) begin
        nx.a_out[h*HALF_W +: HALF_W] = q.b_store[h*HALF_W +: HALF_W];
      end else begin
        nx.a_out[h*HALF_W +: HALF_W] = b_f[h*HALF_W +: HALF_W];
      end
    end

    // the mux is followed by a flop, so a select change moves the
    // output in one clean step with no in-between word

    nx.clka_q = clka_f;
    nx.clkb_q = clkb_f;

    // a full log loses the snapshot, never the capture itself;
    // a new loss in the clearing cycle keeps the flag set
    nx.drop = (q.drop & ~drop_clr) | (log_push & ~lg.in_ready);

    // bus address phase: read data is fetched here and held as a flop
    nx.ph_act = acc;
    nx.ph_wr = hwrite;
    nx.ph_addr = haddr[REG_AW-1:0];
    if (acc && !hwrite) begin
      nx.rdata = rd_word(haddr[REG_AW-1:0], q, lg.out_valid, lg.in_ready,
                         lg.out_data, {b_f, a_f});
    end
  end

  // one snapshot per cycle in which any register loads
  assign log_push = |{ev_a, ev_b};
  assign lg.in_valid = log_push;
  assign lg.in_data = {nx.b_store, nx.a_store};
  assign lg.out_ready = log_pop;

  // reset clears both stores and releases both ports
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      q <= '0;
    end else begin
      q <= nx;
    end
  end

  // pin and bus outputs
  assign a_port_bit_o = q.a_out;
  assign a_port_bit_oe = q.a_oe;
  assign b_port_bit_o = q.b_out;
  assign b_port_bit_oe = q.b_oe;
  assign hrdata = q.rdata;
  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign log_ready = lg.in_ready;

endmodule
`default_nettype wire

/* sim/brt_bus_partner.sv */
// far-side drivers on the a and b buses, with the device's bus keeper
`timescale 1ns/1ps
`default_nettype none
module brt_bus_partner (
  // device side of the pins
  input wire logic [15:0] a_o,
  input wire logic [15:0] a_oe,
  input wire logic [15:0] b_o,
  input wire logic [15:0] b_oe,
  // far-side drivers
  input wire logic [15:0] a_drv,
  input wire logic [15:0] a_en,
  input wire logic [15:0] b_drv,
  input wire logic [15:0] b_en,
  // resolved wire levels
  output logic [15:0] a_pin,
  output logic [15:0] b_pin
);
  // device drive wins; an undriven line keeps the level the device last sampled
  assign a_pin = (a_en & ~a_oe & a_drv) | (~(a_en & ~a_oe) & a_o);
  assign b_pin = (b_en & ~b_oe & b_drv) | (~(b_en & ~b_oe) & b_o);
endmodule
`default_nettype wire

/* sim/brt_top_sva.sv */
// pin-level checks for the transceiver, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module brt_top_sva (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // control pins
  input wire logic [brt_pkg::NUM_HALF-1:0] b_side_drive_enable,
  input wire logic [brt_pkg::NUM_HALF-1:0] a_side_drive_enable_n,
  input wire logic [brt_pkg::NUM_HALF-1:0] b_output_source_select,
  input wire logic [brt_pkg::NUM_HALF-1:0] a_output_source_select,
  // data pins
  input wire logic [brt_pkg::BUS_W-1:0] a_port_bit_i,
  input wire logic [brt_pkg::BUS_W-1:0] a_port_bit_o,
  input wire logic [brt_pkg::BUS_W-1:0] a_port_bit_oe,
  input wire logic [brt_pkg::BUS_W-1:0] b_port_bit_i,
  input wire logic [brt_pkg::BUS_W-1:0] b_port_bit_o,
  input wire logic [brt_pkg::BUS_W-1:0] b_port_bit_oe
);
  import brt_pkg::*;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // six samples: a pin change takes five edges to show, plus the sampling edge
  b_drive_a: assert property (b_side_drive_enable[0] [*6] |-> &b_port_bit_oe[7:0])
    else $error("b port not driven while enabled");
  a_drive_a: assert property ((!a_side_drive_enable_n[1]) [*6] |-> &a_port_bit_oe[15:8])
    else $error("a port not driven while enabled");
  isolate_a: assert property ((!b_side_drive_enable[0] && a_side_drive_enable_n[0]) [*6] |->
    a_port_bit_oe[7:0] == 8'h00 && b_port_bit_oe[7:0] == 8'h00)
    else $error("port driven in isolation");
  live_ab_a: assert property ((b_side_drive_enable[0] && !b_output_source_select[0] &&
    $stable(a_port_bit_i[7:0])) [*6] |-> b_port_bit_o[7:0] == a_port_bit_i[7:0])
    else $error("b port not following live a bus");
  live_ba_a: assert property ((!a_side_drive_enable_n[1] && !a_output_source_select[1] &&
    $stable(b_port_bit_i[15:8])) [*6] |-> a_port_bit_o[15:8] == b_port_bit_i[15:8])
    else $error("a port not following live b bus");
  both_drive_a: assert property ((b_side_drive_enable[1] && !a_side_drive_enable_n[1] &&
    b_output_source_select[1] && a_output_source_select[1]) [*6] |->
    &a_port_bit_oe[15:8] && &b_port_bit_oe[15:8])
    else $error("both ports not driven in stored mode");
  half_oe_a: assert property (a_port_bit_oe[7:0] == {8{a_port_bit_oe[0]}} &&
    b_port_bit_oe[15:8] == {8{b_port_bit_oe[8]}})
    else $error("drive enables split inside a half");
  reset_float_a: assert property ($rose(hresetn) |->
    (a_port_bit_oe == 16'h0000 && b_port_bit_oe == 16'h0000) [*3])
    else $error("port driven right after reset");
endmodule
`default_nettype wire

/* sim/tb_registered_bus_transceiver.sv */
// self-checking bench: modes, captures, select switch, bus hold, registers, log
`timescale 1ns/1ps
`default_nettype none
module tb_registered_bus_transceiver;
  import brt_pkg::*;
  // row: control nibble per half, far-side drive, expected wire levels
  typedef struct packed {
    logic [7:0] m;
    logic [15:0] av, bv, ea, eb;
  } brt_row_t;
  // stored a is 5A34 and stored b is 3C96 while the table runs
  brt_row_t rows [6] = '{
    {8'h33, 16'hA55A, 16'h0000, 16'hA55A, 16'hA55A},
    {8'h77, 16'hA55A, 16'h0000, 16'hA55A, 16'h5A34},
    {8'h00, 16'h0000, 16'h0FF0, 16'h0FF0, 16'h0FF0},
    {8'h88, 16'h0000, 16'h0FF0, 16'h3C96, 16'h0FF0},
    {8'hDD, 16'h0000, 16'h0000, 16'h3C96, 16'h5A34},
    {8'h38, 16'hC300, 16'h0011, 16'hC396, 16'hC311}
  };
  // stimulus, changed only just after a rising edge
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [1:0] htrans = 2'h0, drv_b = 2'h0, drv_an = 2'h3, sel_b = 2'h0, sel_a = 2'h0;
  logic [1:0] cap_a = 2'h0, cap_b = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [15:0] a_drv = 16'h0, b_drv = 16'h0, a_en = 16'h0, b_en = 16'h0;
  // design outputs and resolved wires
  logic [15:0] a_i, a_o, a_oe, b_i, b_o, b_oe;
  logic hreadyout, log_ready, hresp;
  int n_mismatch = 0;
  int n_tests = 0;
  initial forever #2.5 hclk = ~hclk;
  brt_top dut_u (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .b_side_drive_enable(drv_b),
    .a_side_drive_enable_n(drv_an), .b_output_source_select(sel_b),
    .a_output_source_select(sel_a), .a_capture_clock(cap_a), .b_capture_clock(cap_b),
    .a_port_bit_i(a_i), .a_port_bit_o(a_o), .a_port_bit_oe(a_oe), .b_port_bit_i(b_i),
    .b_port_bit_o(b_o), .b_port_bit_oe(b_oe), .log_ready(log_ready)
  );
  brt_bus_partner partner_u (
    .a_o(a_o), .a_oe(a_oe), .b_o(b_o), .b_oe(b_oe), .a_drv(a_drv), .a_en(a_en),
    .b_drv(b_drv), .b_en(b_en), .a_pin(a_i), .b_pin(b_i)
  );
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // bounded wait for hready sampled high at a rising edge
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
  endtask
  // one single word transfer: address phase, then data phase
  task automatic ahb(input logic wr, input logic [7:0] ad, input logic [31:0] wd,
                     output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= {24'h0, ad};
    htrans <= 2'h2;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    q = hrdata;
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] ad, input logic [31:0] e);
    logic [31:0] g;
    ahb(1'b0, ad, 32'h0, g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // far side drives a port only where the device does not
  task automatic set_mode(input logic [7:0] m, input logic [15:0] av, input logic [15:0] bv);
    drv_b <= {m[4], m[0]};
    drv_an <= {m[5], m[1]};
    sel_b <= {m[6], m[2]};
    sel_a <= {m[7], m[3]};
    a_en <= {{8{m[5]}}, {8{m[1]}}};
    b_en <= {{8{!m[4]}}, {8{!m[0]}}};
    a_drv <= av;
    b_drv <= bv;
    repeat (12) @(posedge hclk);
  endtask
  // clock levels held four cycles, well past the sync filter
  task automatic pulse(input logic [1:0] am, input logic [1:0] bm);
    cap_a <= am;
    cap_b <= bm;
    repeat (4) @(posedge hclk);
    cap_a <= 2'b00;
    cap_b <= 2'b00;
    repeat (8) @(posedge hclk);
  endtask
  initial begin
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    rd_chk("store after reset", OFS_STORE, 32'h0);
    chk16("hresp okay", 16'h0000, {15'h0, hresp});
    set_mode(8'h22, 16'h5AC3, 16'h3C96);
    pulse(2'b11, 2'b11);
    rd_chk("store isolation", OFS_STORE, 32'h3C965AC3);
    set_mode(8'h22, 16'h1234, 16'h3C96);
    pulse(2'b01, 2'b00);
    rd_chk("store hold", OFS_STORE, 32'h3C965A34);
    foreach (rows[i]) begin
      set_mode(rows[i].m, rows[i].av, rows[i].bv);
      chk16("a wires", rows[i].ea, a_i);
      chk16("b wires", rows[i].eb, b_i);
    end
    // live to stored: only the old or the new word may ever appear
    set_mode(8'h33, 16'hFFFF, 16'h0000);
    sel_b <= 2'b11;
    repeat (10) begin
      @(posedge hclk);
      if (b_o !== 16'hFFFF) chk16("b during switch", 16'h5A34, b_o);
    end
    chk16("b after switch", 16'h5A34, b_o);
    set_mode(8'h22, 16'h6699, 16'h6699);
    set_mode(8'h11, 16'h0000, 16'h0000);
    chk16("a held", 16'h6699, a_i);
    chk16("b held", 16'h6699, b_i);
    set_mode(8'h33, 16'h0F0F, 16'h0000);
    pulse(2'b11, 2'b11);
    rd_chk("store b driven", OFS_STORE, 32'h0F0F0F0F);
    set_mode(8'h00, 16'h0000, 16'h7117);
    pulse(2'b11, 2'b11);
    rd_chk("store a driven", OFS_STORE, 32'h71177117);
    rd_chk("pins", OFS_PINS, 32'h71177117);
    ahb(1'b1, OFS_CTRL, 32'h000000A5, rd);
    rd_chk("ctrl", OFS_CTRL, 32'h000000A5);
    // override turns the b drive on in both halves while the pins leave it off
    ahb(1'b1, OFS_CTRL, 32'h00000111, rd);
    repeat (8) @(posedge hclk);
    chk16("override b oe", 16'hFFFF, b_oe);
    chk16("override b wires", 16'h7117, b_i);
    ahb(1'b1, OFS_CTRL, 32'h0, rd);
    rd_chk("capt", OFS_CAPT, 32'h0);
    rd_chk("unmapped", 8'h40, 32'h0);
    // log: drain, overfill through register captures, then drain again
    repeat (40) ahb(1'b0, OFS_LOG, 32'h0, rd);
    repeat (LOG_DEPTH + 1) ahb(1'b1, OFS_CAPT, 32'h0000000F, rd);
    chk16("log ready", 16'h0000, {15'h0, log_ready});
    rd_chk("stat full", OFS_STAT, 32'h00000006);
    rd_chk("log head", OFS_LOG, 32'h71177117);
    repeat (LOG_DEPTH - 1) ahb(1'b0, OFS_LOG, 32'h0, rd);
    ahb(1'b1, OFS_STAT, 32'h00000004, rd);
    rd_chk("stat empty", OFS_STAT, 32'h00000001);
    give_verdict();
  end
  // the run needs under a thousand cycles
  initial begin
    repeat (4000) @(posedge hclk);
    n_mismatch++;
    give_verdict();
  end
endmodule
bind brt_top brt_top_sva sva_u (
  .hclk(hclk), .hresetn(hresetn), .b_side_drive_enable(b_side_drive_enable),
  .a_side_drive_enable_n(a_side_drive_enable_n),
  .b_output_source_select(b_output_source_select),
  .a_output_source_select(a_output_source_select), .a_port_bit_i(a_port_bit_i),
  .a_port_bit_o(a_port_bit_o), .a_port_bit_oe(a_port_bit_oe), .b_port_bit_i(b_port_bit_i),
  .b_port_bit_o(b_port_bit_o), .b_port_bit_oe(b_port_bit_oe)
);
`default_nettype wire
